// [hdl/timer16_device.sv]
// Byte access path, shared high-byte holding register and compare output control
// of the 16-bit timer.
// Assumes the processor bus is on clk_i; reads are answered combinationally.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module timer16_device
  import timer16_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Processor bus
  timer16_bus_if.device              bus,
  // Timer events from the counting core
  input  wire logic                  count_step_i,
  input  wire logic                  counting_down_i,
  input  wire logic                  capture_stb_i,
  // Port direction bits
  input  wire logic                  dir_out_a_i,
  input  wire logic                  dir_out_b_i,
  // Waveform pins and status
  output logic                       wave_out_a_o,
  output logic                       wave_out_b_o,
  output logic                       wave_oe_a_o,
  output logic                       wave_oe_b_o,
  output logic                       pin_owned_a_o,
  output logic                       pin_owned_b_o,
  output timer16_pkg::family_type    family_o,
  output timer16_pkg::top_src_type   top_src_o,
  output logic [WORD_W-1:0]          top_value_o
);
  logic [7:0]        holding_r;
  logic [7:0]        control_a_r;
  logic [7:0]        control_b_r;
  logic [WORD_W-1:0] count_value_r;
  logic [WORD_W-1:0] compare_value_a_r;
  logic [WORD_W-1:0] compare_value_b_r;
  logic [WORD_W-1:0] capture_value_r;

  // ==========================================================================
  // Address decode
  wire wr_count_lo = bus.wr && (bus.addr == ADDR_COUNT_LO);
  wire wr_cmpa_lo  = bus.wr && (bus.addr == ADDR_CMP_A_LO);
  wire wr_cmpb_lo  = bus.wr && (bus.addr == ADDR_CMP_B_LO);
  wire wr_cap_lo   = bus.wr && (bus.addr == ADDR_CAPTURE_LO);
  wire wr_hi       = bus.wr && ((bus.addr == ADDR_COUNT_HI) || (bus.addr == ADDR_CMP_A_HI)
                     || (bus.addr == ADDR_CMP_B_HI) || (bus.addr == ADDR_CAPTURE_HI));
  wire rd_count_lo = bus.rd && (bus.addr == ADDR_COUNT_LO);
  wire rd_cap_lo   = bus.rd && (bus.addr == ADDR_CAPTURE_LO);
  wire wr_ctl_a    = bus.wr && (bus.addr == ADDR_CONTROL_A);
  wire wr_ctl_b    = bus.wr && (bus.addr == ADDR_CONTROL_B);
  wire [WORD_W-1:0] wr_word = {holding_r, bus.wdata};

  logic [7:0] rdata_mux;
  always_comb
  begin
    if (bus.addr == ADDR_CONTROL_A)
      rdata_mux = control_a_r & CONTROL_A_MASK;
    else if (bus.addr == ADDR_CONTROL_B)
      rdata_mux = control_b_r & CONTROL_B_MASK;
    else if (bus.addr == ADDR_COUNT_LO)
      rdata_mux = count_value_r[7:0];
    else if (bus.addr == ADDR_COUNT_HI)
      rdata_mux = holding_r;
    else if (bus.addr == ADDR_CMP_A_LO)
      rdata_mux = compare_value_a_r[7:0];
    else if (bus.addr == ADDR_CMP_A_HI)
      rdata_mux = compare_value_a_r[15:8];
    else if (bus.addr == ADDR_CMP_B_LO)
      rdata_mux = compare_value_b_r[7:0];
    else if (bus.addr == ADDR_CMP_B_HI)
      rdata_mux = compare_value_b_r[15:8];
    else if (bus.addr == ADDR_CAPTURE_LO)
      rdata_mux = capture_value_r[7:0];
    else if (bus.addr == ADDR_CAPTURE_HI)
      rdata_mux = holding_r;
    else
      rdata_mux = 8'h00;
  end
  assign bus.rdata = rdata_mux;

  // ==========================================================================
  // Holding register shared by all 16-bit registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      holding_r <= 8'h00;
    else if (wr_hi)
      holding_r <= bus.wdata;
    else if (rd_count_lo)
      holding_r <= count_value_r[15:8];
    else if (rd_cap_lo)
      holding_r <= capture_value_r[15:8];
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      control_a_r <= CONTROL_A_RESET;
      control_b_r <= CONTROL_B_RESET;
    end
    else
    begin
      if (wr_ctl_a)
        control_a_r <= bus.wdata & CONTROL_A_MASK;
      if (wr_ctl_b)
        control_b_r <= bus.wdata & CONTROL_B_MASK;
    end
  end

  wire [1:0] chan_a_output_mode = control_a_r[CHAN_A_MODE_LSB +: 2];
  wire [1:0] chan_b_output_mode = control_a_r[CHAN_B_MODE_LSB +: 2];
  wire [3:0] waveform_select    = {control_b_r[WAVE_HIGH_LSB +: 2],
                                   control_a_r[WAVE_LOW_LSB +: 2]};
  wire waveform_select_top_bit  = waveform_select[3];

  // ==========================================================================
  // Waveform mode decode
  family_type  family;
  top_src_type top_src;
  logic [WORD_W-1:0] top_value;
  always_comb
  begin
    family    = FAMILY_NORMAL;
    top_src   = TOP_FIXED;
    top_value = 16'hFFFF;
    case (waveform_select)
      4'h1, 4'h2, 4'h3:
      begin
        family    = FAMILY_DUAL;
        top_value = {6'h00, waveform_select[1:0] == 2'h1 ? 2'h0 :
                     waveform_select[1:0] == 2'h2 ? 2'h1 : 2'h3, 8'hFF};
      end
      4'h4:
      begin
        top_src   = TOP_COMPARE_A;
        top_value = compare_value_a_r;
      end
      4'h5, 4'h6, 4'h7:
      begin
        family    = FAMILY_FAST;
        top_value = {6'h00, waveform_select[1:0] == 2'h1 ? 2'h0 :
                     waveform_select[1:0] == 2'h2 ? 2'h1 : 2'h3, 8'hFF};
      end
      4'h8, 4'hA:
      begin
        family    = FAMILY_DUAL;
        top_src   = TOP_CAPTURE;
        top_value = capture_value_r;
      end
      4'h9, 4'hB:
      begin
        family    = FAMILY_DUAL;
        top_src   = TOP_COMPARE_A;
        top_value = compare_value_a_r;
      end
      4'hC:
      begin
        top_src   = TOP_CAPTURE;
        top_value = capture_value_r;
      end
      4'hE:
      begin
        family    = FAMILY_FAST;
        top_src   = TOP_CAPTURE;
        top_value = capture_value_r;
      end
      4'hF:
      begin
        family    = FAMILY_FAST;
        top_src   = TOP_COMPARE_A;
        top_value = compare_value_a_r;
      end
      default:
      begin
        family    = FAMILY_NORMAL;
      end
    endcase
  end
  assign family_o    = family;
  assign top_src_o   = top_src;
  assign top_value_o = top_value;

  // ==========================================================================
  // 16-bit registers; a bus write beats the count step and capture.
  wire at_top     = (count_value_r == top_value);
  wire next_count = count_step_i && !wr_count_lo;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_value_r     <= 16'h0000;
      compare_value_a_r <= 16'h0000;
      compare_value_b_r <= 16'h0000;
      capture_value_r   <= 16'h0000;
    end
    else
    begin
      if (wr_count_lo)
        count_value_r <= wr_word;
      else if (next_count)
        count_value_r <= counting_down_i ? count_value_r - 16'h0001
                         : (at_top && family != FAMILY_DUAL) ? 16'h0000
                         : count_value_r + 16'h0001;
      if (wr_cmpa_lo)
        compare_value_a_r <= wr_word;
      if (wr_cmpb_lo)
        compare_value_b_r <= wr_word;
      if (wr_cap_lo)
        capture_value_r <= wr_word;
      else if (capture_stb_i && top_src != TOP_CAPTURE)
        capture_value_r <= count_value_r;
    end
  end

  // ==========================================================================
  // Output channels
  wire match_a = count_step_i && (count_value_r == compare_value_a_r);
  wire match_b = count_step_i && (count_value_r == compare_value_b_r);
  wire top_evt = count_step_i && at_top;

  wave_channel #(.IS_CHAN_A(1'b1)) chan_a (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .mode_i          (chan_a_output_mode),
    .family_i        (family),
    .wave_top_bit_i  (waveform_select_top_bit),
    .dir_out_i       (dir_out_a_i),
    .match_i         (match_a),
    .at_top_i        (top_evt),
    .counting_down_i (counting_down_i),
    .cmp_eq_top_i    (compare_value_a_r == top_value),
    .wave_o          (wave_out_a_o),
    .pin_owned_o     (pin_owned_a_o),
    .pin_oe_o        (wave_oe_a_o)
  );

  wave_channel #(.IS_CHAN_A(1'b0)) chan_b (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .mode_i          (chan_b_output_mode),
    .family_i        (family),
    .wave_top_bit_i  (waveform_select_top_bit),
    .dir_out_i       (dir_out_b_i),
    .match_i         (match_b),
    .at_top_i        (top_evt),
    .counting_down_i (counting_down_i),
    .cmp_eq_top_i    (compare_value_b_r == top_value),
    .wave_o          (wave_out_b_o),
    .pin_owned_o     (pin_owned_b_o),
    .pin_oe_o        (wave_oe_b_o)
  );
endmodule

// [hdl/timer16_pkg.sv]
// Constants shared by the 16-bit timer byte access device and its processor-side master.
// Assumes one clock domain with a synchronous, active-high reset.
package timer16_pkg;

  // ==========================================================================
  // Bus widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int WORD_W = 16;

  // ==========================================================================
  // Byte addresses on the 8-bit bus
  localparam logic [7:0] ADDR_CONTROL_A   = 8'h2F;
  localparam logic [7:0] ADDR_CONTROL_B   = 8'h2E;
  localparam logic [7:0] ADDR_COUNT_HI    = 8'h2D;
  localparam logic [7:0] ADDR_COUNT_LO    = 8'h2C;
  localparam logic [7:0] ADDR_CMP_A_HI    = 8'h2B;
  localparam logic [7:0] ADDR_CMP_A_LO    = 8'h2A;
  localparam logic [7:0] ADDR_CMP_B_HI    = 8'h29;
  localparam logic [7:0] ADDR_CMP_B_LO    = 8'h28;
  localparam logic [7:0] ADDR_CAPTURE_HI  = 8'h25;
  localparam logic [7:0] ADDR_CAPTURE_LO  = 8'h24;

  // ==========================================================================
  // Control register A fields and reset value
  localparam int CHAN_A_MODE_LSB = 6;
  localparam int CHAN_B_MODE_LSB = 4;
  localparam int WAVE_LOW_LSB    = 0;
  localparam logic [7:0] CONTROL_A_RESET = 8'h00;
  localparam logic [7:0] CONTROL_A_MASK  = 8'hF3;
  // Control register B: waveform select upper bits at 4:3.
  localparam int WAVE_HIGH_LSB   = 3;
  localparam logic [7:0] CONTROL_B_RESET = 8'h00;
  localparam logic [7:0] CONTROL_B_MASK  = 8'h18;

  // ==========================================================================
  // Output mode encodings
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_TOGGLE = 2'h1;
  localparam logic [1:0] MODE_CLEAR  = 2'h2;
  localparam logic [1:0] MODE_SET    = 2'h3;

  typedef enum logic [1:0] {
    FAMILY_NORMAL,
    FAMILY_FAST,
    FAMILY_DUAL
  } family_type;

  typedef enum logic [1:0] {
    TOP_FIXED,
    TOP_COMPARE_A,
    TOP_CAPTURE
  } top_src_type;

endpackage

// [hdl/timer16_bus_if.sv]
// Interface carrying the 8-bit processor data bus between master and timer.
// Assumes both ends share clk_i; read data is valid in the cycle rd is high.
`timescale 1ns/1ps
interface timer16_bus_if;
  import timer16_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              wr;
  logic              rd;

  modport device (input addr, input wdata, input wr, input rd, output rdata);
  modport master (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// [hdl/wave_channel.sv]
// One compare output channel: decodes the output mode and drives the waveform bit.
// Assumes match, top and direction strobes come from the same clock domain.
`timescale 1ns/1ps
module wave_channel
  import timer16_pkg::*;
#(
  parameter bit IS_CHAN_A = 1'b1
)
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Control
  input  wire logic [1:0]         mode_i,
  input  wire timer16_pkg::family_type family_i,
  input  wire logic               wave_top_bit_i,
  input  wire logic               dir_out_i,
  // Timer events
  input  wire logic               match_i,
  input  wire logic               at_top_i,
  input  wire logic               counting_down_i,
  input  wire logic               cmp_eq_top_i,
  // Pin
  output logic                    wave_o,
  output logic                    pin_owned_o,
  output logic                    pin_oe_o
);
  logic wave_r;
  logic wave_nxt;

  wire pwm_family   = (family_i != FAMILY_NORMAL);
  wire pwm_toggle   = pwm_family && (mode_i == MODE_TOGGLE) && wave_top_bit_i && IS_CHAN_A;
  wire connected    = (mode_i != MODE_OFF) && !(pwm_family && mode_i == MODE_TOGGLE
                      && !pwm_toggle);
  wire fast_match   = match_i && !(mode_i[1] && cmp_eq_top_i);

  assign pin_owned_o = (mode_i != MODE_OFF);
  assign pin_oe_o    = pin_owned_o && dir_out_i && connected;
  assign wave_o      = wave_r;

  always_comb
  begin
    wave_nxt = wave_r;
    case (family_i)
      FAMILY_NORMAL:
      begin
        if (match_i)
        begin
          if (mode_i == MODE_TOGGLE)
            wave_nxt = !wave_r;
          else if (mode_i == MODE_CLEAR)
            wave_nxt = 1'b0;
          else if (mode_i == MODE_SET)
            wave_nxt = 1'b1;
        end
      end
      FAMILY_FAST:
      begin
        if (pwm_toggle && match_i)
          wave_nxt = !wave_r;
        else if (mode_i[1] && at_top_i)
          wave_nxt = (mode_i == MODE_CLEAR);
        else if (mode_i[1] && fast_match)
          wave_nxt = (mode_i == MODE_SET);
      end
      default:
      begin
        if (pwm_toggle && match_i)
          wave_nxt = !wave_r;
        else if (mode_i[1] && match_i)
          wave_nxt = (mode_i == MODE_SET) ^ counting_down_i;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wave_r <= 1'b0;
    else
      wave_r <= wave_nxt;
  end
endmodule

// [hdl/timer16_master.sv]
// Processor-side end: turns Wishbone word requests into ordered byte operations.
// Assumes a classic Wishbone master on clk_i; adr_i selects the low-byte address.
`timescale 1ns/1ps
module timer16_master
  import timer16_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [ADDR_W-1:0]     adr_i,
  input  wire logic [1:0]            sel_i,
  input  wire logic [WORD_W-1:0]     dat_i,
  output logic [WORD_W-1:0]          dat_o,
  output logic                       ack_o,
  // Timer bus
  timer16_bus_if.master              bus
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SECOND,
    ST_ACK
  } state_type;

  state_type         state_r;
  logic [WORD_W-1:0] dat_r;

  // A new request is taken only when idle, so no access can slip between two bytes.
  wire req       = cyc_i && stb_i && (state_r == ST_IDLE);
  // A 16-bit word is split in two byte operations; sel 2'b01 writes only the low byte,
  // reusing the holding byte already loaded.
  wire low_only  = (sel_i == 2'h1) && we_i;
  wire is_word   = (adr_i[0] == 1'b0) && (adr_i != ADDR_CONTROL_B);

  // First step: write high byte or read low byte; second: the other one.
  assign bus.addr  = (state_r == ST_SECOND) ? (we_i ? adr_i : adr_i + 8'h01)
                     : ((we_i && !low_only && is_word) ? adr_i + 8'h01 : adr_i);
  assign bus.wdata = (state_r == ST_SECOND || !is_word || low_only) ? dat_i[7:0] : dat_i[15:8];
  assign bus.wr    = we_i && (req || state_r == ST_SECOND);
  assign bus.rd    = !we_i && (req || state_r == ST_SECOND);
  assign ack_o     = (state_r == ST_ACK);
  assign dat_o     = dat_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      dat_r   <= 16'h0000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (req)
          begin
            dat_r   <= {8'h00, bus.rdata};
            state_r <= (is_word && !low_only) ? ST_SECOND : ST_ACK;
          end
        end
        ST_SECOND:
        begin
          if (!we_i)
            dat_r <= {bus.rdata, dat_r[7:0]};
          state_r <= ST_ACK;
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// [bench/timer16_bus_properties.sv]
// Assertions on the byte bus between the timer device and its processor-side master.
// Assumes one clock with a synchronous active-high reset; read data is combinational.
`timescale 1ns/1ps
module timer16_bus_properties
  import timer16_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Byte bus
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic              wr,
  input  wire logic              rd
);
  // ==========================================================================
  // Shadow of the holding byte, both compare values and control A
  logic [7:0]  hold_r;
  logic [15:0] cmp_a_r;
  logic [15:0] cmp_b_r;
  logic [7:0]  ctrl_r;
  wire         hi_wr    = wr && (addr inside {ADDR_COUNT_HI, ADDR_CMP_A_HI, ADDR_CMP_B_HI,
                                              ADDR_CAPTURE_HI});
  wire         hold_rd  = rd && (addr inside {ADDR_COUNT_HI, ADDR_CAPTURE_HI});
  wire         lo_rd    = rd && (addr inside {ADDR_COUNT_LO, ADDR_CMP_A_LO, ADDR_CMP_B_LO,
                                              ADDR_CAPTURE_LO});
  wire         cmp_rd   = rd && (addr[7:2] == 6'h0A);
  wire         ctrl_rd  = rd && (addr == ADDR_CONTROL_A);
  wire [15:0]  cmp_w    = addr[1] ? cmp_a_r : cmp_b_r;
  wire [7:0]   cmp_byte = addr[0] ? cmp_w[15:8] : cmp_w[7:0];

  // A count or capture high-half read shows the holding byte, so the shadow learns it there.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_r  <= 8'h00;
      cmp_a_r <= 16'h0000;
      cmp_b_r <= 16'h0000;
      ctrl_r  <= CONTROL_A_RESET;
    end
    else
    begin
      if (hi_wr)
        hold_r <= wdata;
      else if (hold_rd)
        hold_r <= rdata;
      if (wr && addr == ADDR_CMP_A_LO)
        cmp_a_r <= {hold_r, wdata};
      if (wr && addr == ADDR_CMP_B_LO)
        cmp_b_r <= {hold_r, wdata};
      if (wr && addr == ADDR_CONTROL_A)
        ctrl_r <= wdata & CONTROL_A_MASK;
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_strobe_excl : assert property (!(wr && rd))
    else $error("read and write strobes high together");
  chk_byte_strobe : assert property (wr |=> !(wr && $stable(addr)))
    else $error("write strobe held on one byte address");
  chk_lo_read_pairs : assert property (lo_rd |=> rd && addr == $past(addr) + 8'h01)
    else $error("low byte read not followed by high byte read");
  chk_hi_after_lo : assert property (hold_rd |-> $past(rd) && $past(addr) == addr - 8'h01)
    else $error("held high byte read without low byte read before it");
  chk_cmp_lo_value : assert property (cmp_rd && !addr[0] |-> rdata == cmp_byte)
    else $error("compare low byte differs from written word");
  chk_cmp_hi_direct : assert property (cmp_rd && addr[0] |-> rdata == cmp_byte)
    else $error("compare high byte not returned directly");
  chk_ctrl_value : assert property (ctrl_rd |-> rdata == ctrl_r)
    else $error("control A read differs from written value");
  chk_ctrl_reserved : assert property (ctrl_rd |-> (rdata & ~CONTROL_A_MASK) == 8'h00)
    else $error("control A reserved bits read nonzero");
endmodule

// [bench/tb.sv]
// Self-checking bench: Wishbone words into the master, byte bus into the timer device.
// Assumes a 25 MHz clock and a synchronous active-high reset held for five cycles.
`timescale 1ns/1ps
module tb;
  import timer16_pkg::*;

  // ==========================================================================
  // Signals
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0]  adr = 8'h00;
  logic [1:0]  sel = 2'h0;
  logic [15:0] dat_w = 16'h0000, dat_r, top_value, junk;
  logic        step_en = 1'b0, down = 1'b0, cap_stb = 1'b0, dir_a = 1'b0, dir_b = 1'b0;
  logic        wave_a, wave_b, oe_a, oe_b, own_a, own_b;
  family_type  family;
  top_src_type top_src;
  int          errors = 0;
  int          n_checks = 0;

  timer16_bus_if bus ();
  timer16_master u_timer16_master (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .bus(bus));
  timer16_device u_timer16_device (.clk_i(clk_i), .rst_i(rst_i), .bus(bus),
    .count_step_i(step_en), .counting_down_i(down), .capture_stb_i(cap_stb),
    .dir_out_a_i(dir_a), .dir_out_b_i(dir_b), .wave_out_a_o(wave_a), .wave_out_b_o(wave_b),
    .wave_oe_a_o(oe_a), .wave_oe_b_o(oe_b), .pin_owned_a_o(own_a), .pin_owned_b_o(own_b),
    .family_o(family), .top_src_o(top_src), .top_value_o(top_value));
  timer16_bus_properties u_timer16_bus_properties (.clk_i(clk_i), .rst_i(rst_i),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .wr(bus.wr), .rd(bus.rd));

  always #20 clk_i = ~clk_i;

  // ==========================================================================
  // Shared tasks
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [1:0] s,
                    input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      errors++;
      $display("unexpected ack: expected 1, seen %b", ack);
      summarize();
    end
    else
    begin
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    wb(1'b0, a, 2'b11, 16'h0000, q);
    check(name, e, (a[0] || a == ADDR_CONTROL_B) ? (q & 16'h00FF) : q);
  endtask

  task automatic set_ctrl(input logic [7:0] a, input logic [7:0] b);
    wb(1'b1, ADDR_CONTROL_A, 2'b01, {8'h00, a}, junk);
    wb(1'b1, ADDR_CONTROL_B, 2'b01, {8'h00, b}, junk);
    @(posedge clk_i);
  endtask

  task automatic run(input logic [15:0] start, input int n);
    wb(1'b1, ADDR_COUNT_LO, 2'b11, start, junk);
    // The step strobe is touched only when steps are asked for, never twice in one step.
    if (n > 0)
    begin
      step_en <= 1'b1;
      repeat (n) @(posedge clk_i);
      step_en <= 1'b0;
    end
    @(posedge clk_i);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_regs();
    rd_chk("control_a", ADDR_CONTROL_A, 16'h0000);
    set_ctrl(8'hFF, 8'hFF);
    rd_chk("control_a", ADDR_CONTROL_A, 16'h00F3);
    rd_chk("control_b", ADDR_CONTROL_B, 16'h0018);
    rd_chk("unmapped", 8'h30, 16'h0000);
    set_ctrl(8'h00, 8'h00);
    run(16'h12FF, 0);
    rd_chk("count", ADDR_COUNT_LO, 16'h12FF);
    run(16'h12FF, 1);
    rd_chk("count", ADDR_COUNT_LO, 16'h1300);
    run(16'hA55A, 0);
    cap_stb <= 1'b1;
    @(posedge clk_i);
    cap_stb <= 1'b0;
    rd_chk("capture", ADDR_CAPTURE_LO, 16'hA55A);
  endtask

  task automatic test_holding();
    wb(1'b1, ADDR_CMP_A_LO, 2'b11, 16'hBEEF, junk);
    rd_chk("compare_a", ADDR_CMP_A_LO, 16'hBEEF);
    wb(1'b1, ADDR_CMP_B_LO, 2'b01, 16'h0077, junk);
    rd_chk("compare_b", ADDR_CMP_B_LO, 16'hBE77);
    wb(1'b1, ADDR_CMP_A_HI, 2'b01, 16'h0099, junk);
    rd_chk("compare_a", ADDR_CMP_A_LO, 16'hBEEF);
    wb(1'b1, ADDR_CMP_B_LO, 2'b01, 16'h0044, junk);
    rd_chk("compare_b", ADDR_CMP_B_LO, 16'h9944);
    rd_chk("count", ADDR_COUNT_LO, 16'hA55A);
    wb(1'b1, ADDR_CMP_A_LO, 2'b01, 16'h0011, junk);
    rd_chk("compare_a", ADDR_CMP_A_LO, 16'hA511);
  endtask

  task automatic test_normal();
    logic [1:0] m;
    wb(1'b1, ADDR_CMP_A_LO, 2'b11, 16'h0005, junk);
    wb(1'b1, ADDR_CMP_B_LO, 2'b01, 16'h0005, junk);
    dir_a <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(3 - i);
      set_ctrl({m, m, 4'h0}, 8'h00);
      check("owned_a", 16'(m != MODE_OFF), 16'(own_a));
      check("owned_b", 16'(m != MODE_OFF), 16'(own_b));
      check("oe_a", 16'(m != MODE_OFF), 16'(oe_a));
      check("oe_b", 16'h0000, 16'(oe_b));
      run(16'h0003, 3);
      if (m != MODE_OFF)
      begin
        check("wave_a", 16'(m != MODE_CLEAR), 16'(wave_a));
        check("wave_b", 16'(m != MODE_CLEAR), 16'(wave_b));
      end
    end
    dir_b <= 1'b1;
    set_ctrl(8'h20, 8'h00);
    check("oe_b", 16'h0001, 16'(oe_b));
    check("oe_a", 16'h0000, 16'(oe_a));
  endtask

  task automatic test_table();
    logic [3:0]  wgm_t[6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'hF};
    family_type  fam_t[6] = '{FAMILY_NORMAL, FAMILY_DUAL, FAMILY_NORMAL, FAMILY_FAST,
                              FAMILY_DUAL, FAMILY_FAST};
    top_src_type src_t[6] = '{TOP_FIXED, TOP_FIXED, TOP_COMPARE_A, TOP_FIXED, TOP_CAPTURE,
                              TOP_COMPARE_A};
    logic [15:0] top_t[6] = '{16'hFFFF, 16'h00FF, 16'h0005, 16'h00FF, 16'hA55A, 16'h0005};
    for (int i = 0; i < 6; i++)
    begin
      set_ctrl({6'h00, wgm_t[i][1:0]}, {3'h0, wgm_t[i][3:2], 3'h0});
      check("family", 16'(fam_t[i]), 16'(family));
      check("top_source", 16'(src_t[i]), 16'(top_src));
      check("top_value", top_t[i], top_value);
    end
  endtask

  task automatic test_pwm();
    logic [1:0] m;
    for (int i = 0; i < 2; i++)
    begin
      m = 2'(2 + i);
      set_ctrl({m, m, 4'h1}, 8'h08);
      run(16'h0003, 3);
      check("wave_a", 16'(m == MODE_SET), 16'(wave_a));
      run(16'h00FE, 2);
      check("wave_a", 16'(m == MODE_CLEAR), 16'(wave_a));
      set_ctrl({m, m, 4'h1}, 8'h00);
      down <= 1'b0;
      run(16'h0003, 3);
      check("wave_a", 16'(m == MODE_SET), 16'(wave_a));
      down <= 1'b1;
      run(16'h0007, 3);
      check("wave_a", 16'(m == MODE_CLEAR), 16'(wave_a));
      down <= 1'b0;
    end
    set_ctrl(8'h51, 8'h08);
    check("oe_a", 16'h0000, 16'(oe_a));
    check("oe_b", 16'h0000, 16'(oe_b));
    set_ctrl(8'h53, 8'h18);
    check("oe_a", 16'h0001, 16'(oe_a));
    check("oe_b", 16'h0000, 16'(oe_b));
    run(16'h0003, 3);
    check("wave_a", 16'h0001, 16'(wave_a));
    check("wave_b", 16'h0000, 16'(wave_b));
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    test_regs();
    test_holding();
    test_normal();
    test_table();
    test_pwm();
    summarize();
  end
endmodule
